/* File: hw/vrt_pkg.sv */
// vrt_pkg: register map, reset values, link framing and carriers for the
// regulator telemetry and configuration register bank.
// assumes one system clock domain; the link clock is sampled, not used as a clock.
package vrt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] REG_CAPABILITY = 8'h06;
    localparam logic [7:0] REG_STATUS_TWO = 8'h11;
    localparam logic [7:0] REG_OUT_CURRENT = 8'h15;
    localparam logic [7:0] REG_OUT_VOLTAGE = 8'h16;
    localparam logic [7:0] REG_TEMPERATURE = 8'h17;
    localparam logic [7:0] REG_OUT_POWER = 8'h18;
    localparam logic [7:0] REG_IN_VOLTAGE = 8'h1a;
    localparam logic [7:0] REG_IN_POWER = 8'h1b;
    localparam logic [7:0] REG_STATUS_TWO_COPY = 8'h1c;
    localparam logic [7:0] REG_MAX_CURRENT = 8'h21;
    localparam logic [7:0] REG_MAX_TEMP = 8'h22;
    localparam logic [7:0] REG_FAST_SLEW = 8'h24;
    localparam logic [7:0] REG_SLOW_SLEW = 8'h25;
    localparam logic [7:0] REG_BOOT_CODE = 8'h26;
    localparam logic [7:0] REG_SLOW_SELECT = 8'h2a;
    localparam logic [7:0] REG_DEEP_EXIT = 8'h2b;
    localparam logic [7:0] REG_THIRD_EXIT = 8'h2c;
    localparam logic [7:0] REG_EN_READY = 8'h2d;
    localparam logic [7:0] REG_IN_POWER_MAX = 8'h2e;
    localparam logic [7:0] REG_IN_POWER_ALERT = 8'h2f;
    localparam logic [7:0] REG_MAX_VCODE = 8'h30;
    localparam logic [7:0] REG_TARGET_VCODE = 8'h31;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and fixed contents
    localparam logic [7:0] RST_OUT_CURRENT = 8'h01;
    localparam logic [7:0] RST_OUT_VOLTAGE = 8'h01;
    localparam logic [7:0] RST_TEMPERATURE = 8'h00;
    localparam logic [7:0] RST_OUT_POWER = 8'h01;
    localparam logic [7:0] RST_IN_VOLTAGE = 8'h00;
    localparam logic [7:0] RST_STATUS_COPY = 8'h00;
    localparam logic [7:0] RST_MAX_CURRENT = 8'h00;
    localparam logic [7:0] RST_MAX_TEMP = 8'h6a;
    localparam logic [7:0] RST_SLOW_SELECT = 8'h01;
    localparam logic [7:0] RST_MAX_VCODE = 8'hfb;
    localparam logic [7:0] VAL_DEEP_EXIT = 8'h8c;
    localparam logic [7:0] VAL_THIRD_EXIT = 8'h55;
    localparam logic [7:0] VAL_EN_READY = 8'hca;
    localparam logic [7:0] VAL_CAPABILITY = 8'hd7;
    localparam int CAP_CURRENT_FORMAT_BIT = 7;
    localparam logic [7:0] SLOW_SELECT_MIN = 8'h01;
    localparam logic [7:0] SLOW_SELECT_MAX = 8'h04;
    localparam logic [7:0] READ_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // conversion constants
    localparam int VOUT_MV_PER_STEP_LOG2 = 3;
    localparam logic [15:0] CURRENT_FULL_SCALE = 16'h00ff;
    localparam logic [31:0] VIN_MV_PER_V = 32'h0000_03e8;
    localparam logic [31:0] VIN_STEPS_PER_V = 32'h0000_0007;
    localparam logic [31:0] VIN_CODE_OFFSET = 32'h0000_0002;

    ////////////////////////////////////////////////////////////////////////////
    // link framing: start bit, command, address, payload, then ack and data
    localparam logic [3:0] CMD_SET_TARGET_FAST = 4'h1;
    localparam logic [3:0] CMD_SET_TARGET_SLOW = 4'h2;
    localparam logic [3:0] CMD_SET_POWER_STATE = 4'h3;
    localparam logic [3:0] CMD_GET_REG = 4'h5;
    localparam logic [3:0] CMD_SET_REG = 4'h6;
    localparam logic [1:0] ACK_OK = 2'h2;
    localparam logic [1:0] ACK_NOT_SUPPORTED = 2'h3;
    localparam logic [4:0] HDR_BITS = 5'h14;
    localparam logic [4:0] RESP_BITS = 5'h0a;

    typedef enum logic [1:0] {LINK_IDLE, LINK_HDR, LINK_RESP} vrt_phase_type;

    typedef struct packed {
        logic valid;
        logic [7:0] current_amps;
        logic [11:0] sense_pos_mv;
        logic [11:0] sense_neg_mv;
        logic [7:0] temp_c;
        logic [15:0] input_mv;
    } vrt_telemetry_type;

    typedef struct packed {
        logic clk_meta;
        logic clk_sync;
        logic clk_prev;
        logic dat_meta;
        logic dat_sync;
        vrt_phase_type phase;
        logic [4:0] bit_cnt;
        logic [19:0] hdr;
        logic [9:0] resp;
        logic dat_out;
        logic dat_oe;
        logic strap_done;
        logic [7:0] out_current;
        logic [7:0] out_voltage;
        logic [7:0] temperature;
        logic [7:0] out_power;
        logic [7:0] in_voltage;
        logic [7:0] status_copy;
        logic [7:0] max_current;
        logic [7:0] max_temp;
        logic [7:0] slow_select;
        logic [7:0] slow_rate;
        logic [7:0] max_vcode;
        logic [7:0] boot_code;
        logic [7:0] target_code;
        logic target_slow;
        logic target_update;
        logic alert_n;
    } vrt_state_type;

endpackage : vrt_pkg

/* File: hw/vrt_regs.sv */
// vrt_regs: telemetry and configuration register bank behind the serial
// voltage-code link, with the link slave that reads and writes it.
// assumes telemetry, status and straps come from logic on i_clk; link pins are
// asynchronous and resynchronised; the wire level is resolved outside.
//
// What this block does
// - output current reads ff when current equals the latched maximum current
// - output voltage is differential sense reading at 8 mV per step
// - temperature reads in whole degrees Celsius; zero means not measured
// - output power is the upper byte of output voltage reading times output current reading
// - input voltage code is seven steps per volt plus two
// - reading status two copies the value read into the last-read copy
// - peak current pin is latched once after each reset release, then read-only
// - writable temperature limit, default 106 C, drives the overtemperature alert
// - fast slew rate is read-only, 10 or 30 mV/us
// - slow slew rate is fast rate divided by 2, 4, 8 or 16
// - target starts at strapped boot code until a new set-target command
// - deepest-state exit latency reads a fixed microsecond value
// - third-state exit latency reads a fixed microsecond value
// - enable-to-ready latency reads a fixed value
// - codes above the programmed maximum get a not-supported acknowledge
// - current target code is a read-write register
// - capability bit 7 set: current full scale equals maximum current
module vrt_regs
    import vrt_pkg::*;
#(
    parameter int FAST_SLEW_MV_US = 10
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_link_clk,
    input wire logic i_link_data,
    output logic o_link_data,
    output logic o_link_data_oe,
    input wire vrt_telemetry_type i_telemetry,
    input wire logic [7:0] i_status_two,
    input wire logic [7:0] i_peak_current_program_pin,
    input wire logic [7:0] i_boot_code_strap,
    output logic [7:0] o_target_code,
    output logic o_target_slow,
    output logic o_target_update,
    output logic [7:0] o_slow_slew_rate,
    output logic o_overtemperature_alert_out_n
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (!(FAST_SLEW_MV_US == 10 || FAST_SLEW_MV_US == 30)) begin : g_bad_slew
        $error("fast slew rate must be 10 or 30");
    end

    localparam logic [7:0] FAST_RATE = 8'(FAST_SLEW_MV_US);

    vrt_state_type st_reg;
    vrt_state_type st_next;
    logic link_rise;
    logic exec_now;
    logic [19:0] frame;

    ////////////////////////////////////////////////////////////////////////////
    // register read decode: {hit, data}
    function automatic logic [8:0] read_reg(input logic [7:0] addr,
                                            input vrt_state_type s,
                                            input logic [7:0] status_two);
        logic [8:0] r;
        r = {1'b1, READ_ZERO};
        case (addr)
            REG_CAPABILITY: r[7:0] = VAL_CAPABILITY | (8'h01 << CAP_CURRENT_FORMAT_BIT);
            REG_STATUS_TWO: r[7:0] = status_two;
            REG_OUT_CURRENT: r[7:0] = s.out_current;
            REG_OUT_VOLTAGE: r[7:0] = s.out_voltage;
            REG_TEMPERATURE: r[7:0] = s.temperature;
            REG_OUT_POWER: r[7:0] = s.out_power;
            REG_IN_VOLTAGE: r[7:0] = s.in_voltage;
            REG_IN_POWER: r[7:0] = READ_ZERO;
            REG_STATUS_TWO_COPY: r[7:0] = s.status_copy;
            REG_MAX_CURRENT: r[7:0] = s.max_current;
            REG_MAX_TEMP: r[7:0] = s.max_temp;
            REG_FAST_SLEW: r[7:0] = FAST_RATE;
            REG_SLOW_SLEW: r[7:0] = s.slow_rate;
            REG_BOOT_CODE: r[7:0] = s.boot_code;
            REG_SLOW_SELECT: r[7:0] = s.slow_select;
            REG_DEEP_EXIT: r[7:0] = VAL_DEEP_EXIT;
            REG_THIRD_EXIT: r[7:0] = VAL_THIRD_EXIT;
            REG_EN_READY: r[7:0] = VAL_EN_READY;
            REG_IN_POWER_MAX: r[7:0] = READ_ZERO;
            REG_IN_POWER_ALERT: r[7:0] = READ_ZERO;
            REG_MAX_VCODE: r[7:0] = s.max_vcode;
            REG_TARGET_VCODE: r[7:0] = s.target_code;
            default: r = {1'b0, READ_ZERO};
        endcase
        return r;
    endfunction : read_reg

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [11:0] vdiff;
        logic [15:0] cur_scaled;
        logic [15:0] power_prod;
        logic [31:0] vin_calc;
        logic [8:0] rd;
        logic [1:0] ack;
        logic [3:0] cmd;
        logic [7:0] addr;
        logic [7:0] pay;
        vdiff = 12'h000;
        cur_scaled = 16'h0000;
        power_prod = 16'h0000;
        vin_calc = 32'h0000_0000;
        rd = 9'h000;
        ack = ACK_OK;
        cmd = frame[19:16];
        addr = frame[15:8];
        pay = frame[7:0];

        st_next = st_reg;
        st_next.target_update = 1'b0;
        st_next.clk_meta = i_link_clk;
        st_next.clk_sync = st_reg.clk_meta;
        st_next.clk_prev = st_reg.clk_sync;
        st_next.dat_meta = i_link_data;
        st_next.dat_sync = st_reg.dat_meta;

        // straps are caught on the first edge after reset release
        if (!st_reg.strap_done) begin
            st_next.strap_done = 1'b1;
            st_next.max_current = i_peak_current_program_pin;
            st_next.boot_code = i_boot_code_strap;
            st_next.target_code = i_boot_code_strap;
            st_next.target_slow = 1'b0;
            st_next.target_update = 1'b1;
        end

        // telemetry conversion, only once the current limit is known
        if (st_reg.strap_done && i_telemetry.valid) begin
            if (st_reg.max_current == 8'h00) begin
                cur_scaled = CURRENT_FULL_SCALE;
            end else begin
                cur_scaled = (16'(i_telemetry.current_amps) * CURRENT_FULL_SCALE)
                    / {8'h00, st_reg.max_current};
            end
            st_next.out_current = (cur_scaled > CURRENT_FULL_SCALE) ? 8'hff : cur_scaled[7:0];
            if (i_telemetry.sense_pos_mv > i_telemetry.sense_neg_mv) begin
                vdiff = i_telemetry.sense_pos_mv - i_telemetry.sense_neg_mv;
            end
            // saturate: differences past 2 V do not fit eight bits
            st_next.out_voltage = vdiff[11] ? 8'hff : vdiff[10:VOUT_MV_PER_STEP_LOG2];
            st_next.temperature = i_telemetry.temp_c;
            // keep the upper byte so the product stays in eight bits
            power_prod = 16'(st_next.out_voltage) * 16'(st_next.out_current);
            st_next.out_power = power_prod[15:8];
            vin_calc = (32'(i_telemetry.input_mv) * VIN_STEPS_PER_V) / VIN_MV_PER_V
                + VIN_CODE_OFFSET;
            st_next.in_voltage = (vin_calc > 32'h0000_00ff) ? 8'hff : vin_calc[7:0];
        end

        // a zero temperature means no sensor, so it never raises the alert
        st_next.alert_n = !((st_reg.temperature != 8'h00)
            && (st_reg.temperature >= st_reg.max_temp));

        // serial link slave
        case (st_reg.phase)
            LINK_IDLE: begin
                if (link_rise && !st_reg.dat_sync) begin
                    st_next.phase = LINK_HDR;
                    st_next.bit_cnt = 5'h00;
                end
            end
            LINK_HDR: begin
                if (link_rise) begin
                    st_next.hdr = frame;
                    st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                    if (exec_now) begin
                        rd = {1'b1, READ_ZERO};
                        case (cmd)
                            CMD_SET_TARGET_FAST, CMD_SET_TARGET_SLOW: begin
                                if (pay > st_reg.max_vcode) begin
                                    ack = ACK_NOT_SUPPORTED;
                                end else begin
                                    st_next.target_code = pay;
                                    st_next.target_slow = (cmd == CMD_SET_TARGET_SLOW);
                                    st_next.target_update = 1'b1;
                                end
                            end
                            CMD_SET_POWER_STATE: ack = ACK_OK;
                            CMD_GET_REG: begin
                                rd = read_reg(addr, st_reg, i_status_two);
                                if (addr == REG_STATUS_TWO) begin
                                    st_next.status_copy = i_status_two;
                                end
                            end
                            CMD_SET_REG: begin
                                case (addr)
                                    REG_MAX_TEMP: st_next.max_temp = pay;
                                    REG_SLOW_SELECT: begin
                                        if (pay >= SLOW_SELECT_MIN && pay <= SLOW_SELECT_MAX) begin
                                            st_next.slow_select = pay;
                                        end else begin
                                            ack = ACK_NOT_SUPPORTED;
                                        end
                                    end
                                    REG_MAX_VCODE: st_next.max_vcode = pay;
                                    REG_TARGET_VCODE: begin
                                        if (pay > st_reg.max_vcode) begin
                                            ack = ACK_NOT_SUPPORTED;
                                        end else begin
                                            st_next.target_code = pay;
                                            st_next.target_update = 1'b1;
                                        end
                                    end
                                    default: begin
                                        // read-only targets keep their contents
                                        rd = read_reg(addr, st_reg, i_status_two);
                                        rd[7:0] = READ_ZERO;
                                    end
                                endcase
                            end
                            default: rd = {1'b0, READ_ZERO};
                        endcase
                        if (!rd[8]) begin
                            ack = ACK_NOT_SUPPORTED;
                        end
                        st_next.phase = LINK_RESP;
                        st_next.bit_cnt = 5'h00;
                        st_next.dat_oe = 1'b1;
                        st_next.dat_out = ack[1];
                        st_next.resp = {ack[0], rd[7:0], 1'b0};
                    end
                end
            end
            LINK_RESP: begin
                if (link_rise) begin
                    if (st_reg.bit_cnt == RESP_BITS - 5'h01) begin
                        st_next.phase = LINK_IDLE;
                        st_next.dat_oe = 1'b0;
                        st_next.dat_out = 1'b1;
                    end else begin
                        st_next.dat_out = st_reg.resp[9];
                        st_next.resp = {st_reg.resp[8:0], 1'b0};
                        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                    end
                end
            end
            default: begin
                st_next.phase = LINK_IDLE;
                st_next.dat_oe = 1'b0;
            end
        endcase

        st_next.slow_rate = FAST_RATE >> st_next.slow_select[2:0];
    end

    assign link_rise = st_reg.clk_sync & ~st_reg.clk_prev;
    assign frame = {st_reg.hdr[18:0], st_reg.dat_sync};
    assign exec_now = (st_reg.phase == LINK_HDR) && link_rise
        && (st_reg.bit_cnt == HDR_BITS - 5'h01);

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= '0;
            st_reg.phase <= LINK_IDLE;
            st_reg.dat_out <= 1'b1;
            st_reg.out_current <= RST_OUT_CURRENT;
            st_reg.out_voltage <= RST_OUT_VOLTAGE;
            st_reg.temperature <= RST_TEMPERATURE;
            st_reg.out_power <= RST_OUT_POWER;
            st_reg.in_voltage <= RST_IN_VOLTAGE;
            st_reg.status_copy <= RST_STATUS_COPY;
            st_reg.max_current <= RST_MAX_CURRENT;
            st_reg.max_temp <= RST_MAX_TEMP;
            st_reg.slow_select <= RST_SLOW_SELECT;
            st_reg.slow_rate <= FAST_RATE >> RST_SLOW_SELECT[2:0];
            st_reg.max_vcode <= RST_MAX_VCODE;
            st_reg.alert_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_link_data = st_reg.dat_out;
    assign o_link_data_oe = st_reg.dat_oe;
    assign o_target_code = st_reg.target_code;
    assign o_target_slow = st_reg.target_slow;
    assign o_target_update = st_reg.target_update;
    assign o_slow_slew_rate = st_reg.slow_rate;
    assign o_overtemperature_alert_out_n = st_reg.alert_n;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_set_target_frame;
        exec_now && (frame[19:16] == CMD_SET_TARGET_FAST
            || frame[19:16] == CMD_SET_TARGET_SLOW);
    endsequence

    sequence s_ack_driven(logic [1:0] code);
        (o_link_data_oe && o_link_data == code[1]) ##1 (o_link_data_oe [*1]);
    endsequence

    property p_alert_level;
        @(posedge i_clk) disable iff (!i_arst_n)
        ##1 (o_overtemperature_alert_out_n == !($past(st_reg.temperature) != 8'h00
            && $past(st_reg.temperature) >= $past(st_reg.max_temp)));
    endproperty
    a_alert_level: assert property (p_alert_level) else $error("alert level wrong");

    property p_reject_high_code;
        @(posedge i_clk) disable iff (!i_arst_n)
        (s_set_target_frame and (frame[7:0] > st_reg.max_vcode))
        |=> ($stable(o_target_code) && !o_target_update) and s_ack_driven(ACK_NOT_SUPPORTED);
    endproperty
    a_reject_high_code: assert property (p_reject_high_code) else $error("high code taken");

    property p_accept_code;
        @(posedge i_clk) disable iff (!i_arst_n)
        (s_set_target_frame and (frame[7:0] <= st_reg.max_vcode))
        |=> ((o_target_code == $past(frame[7:0])) && o_target_update)
            and s_ack_driven(ACK_OK);
    endproperty
    a_accept_code: assert property (p_accept_code) else $error("target not updated");

    property p_status_copy;
        @(posedge i_clk) disable iff (!i_arst_n)
        (exec_now && frame[19:16] == CMD_GET_REG && frame[15:8] == REG_STATUS_TWO)
        |=> st_reg.status_copy == $past(i_status_two) && st_reg.resp[8:1] == $past(i_status_two);
    endproperty
    a_status_copy: assert property (p_status_copy) else $error("status copy missed");

    property p_max_current_frozen;
        @(posedge i_clk) disable iff (!i_arst_n)
        st_reg.strap_done |=> $stable(st_reg.max_current);
    endproperty
    a_max_current_frozen: assert property (p_max_current_frozen) else $error("limit moved");

    property p_ro_write_ignored;
        @(posedge i_clk) disable iff (!i_arst_n)
        (exec_now && frame[19:16] == CMD_SET_REG && frame[15:8] == REG_MAX_CURRENT)
        |=> $stable(st_reg.max_current) ##1 $stable(st_reg.max_current);
    endproperty
    a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("ro reg written");

    property p_power_product;
        @(posedge i_clk) disable iff (!i_arst_n)
        $past(st_reg.strap_done && i_telemetry.valid)
        |-> 16'(st_reg.out_power) == ((16'(st_reg.out_voltage) * 16'(st_reg.out_current)) >> 8);
    endproperty
    a_power_product: assert property (p_power_product) else $error("power wrong");

    property p_slow_rate;
        @(posedge i_clk) disable iff (!i_arst_n)
        o_slow_slew_rate == (FAST_RATE >> st_reg.slow_select[2:0])
            && st_reg.slow_select >= SLOW_SELECT_MIN && st_reg.slow_select <= SLOW_SELECT_MAX;
    endproperty
    a_slow_rate: assert property (p_slow_rate) else $error("slow rate wrong");

    property p_boot_target;
        @(posedge i_clk) disable iff (!i_arst_n)
        !st_reg.strap_done |=> o_target_code == $past(i_boot_code_strap) && o_target_update;
    endproperty
    a_boot_target: assert property (p_boot_target) else $error("boot code not loaded");

    property p_voltage_step;
        @(posedge i_clk) disable iff (!i_arst_n)
        $past(st_reg.strap_done && i_telemetry.valid
            && i_telemetry.sense_pos_mv < 12'h800 && i_telemetry.sense_neg_mv == 12'h000)
        |-> 12'(st_reg.out_voltage) == ($past(i_telemetry.sense_pos_mv) >> 3);
    endproperty
    a_voltage_step: assert property (p_voltage_step) else $error("voltage step wrong");

endmodule : vrt_regs

/* File: test/vrt_link_master.sv */
// vrt_link_master: behavioural link master, one frame per call.
// assumes the bench resolves the wire; data high means released.
module vrt_link_master #(parameter realtime HALF = 62.5) (
    output logic o_link_clk = 1'b0,
    output logic o_data = 1'b1,
    input wire logic i_wire
);
    timeunit 1ns / 100ps;
    task automatic frame(input logic [19:0] hdr, output logic [9:0] resp);
        for (int i = 20; i >= 0; i--) begin
            o_data = i < 20 ? hdr[i] : 1'b0;
            #HALF o_link_clk = 1'b1;
            #HALF o_link_clk = 1'b0;
        end
        o_data = 1'b1; // released, the device owns the answer
        for (int i = 9; i >= 0; i--) begin
            #HALF o_link_clk = 1'b1;
            resp[i] = i_wire;
            #HALF o_link_clk = 1'b0;
        end
        #(4 * HALF);
    endtask : frame
endmodule : vrt_link_master

/* File: test/vrt_regs_tb.sv */
// vrt_regs_tb: self-checking bench for the register bank over its link.
// assumes vrt_link_master as the far side; device drive wins the wire.
module vrt_regs_tb import vrt_pkg::*; ;
    timeunit 1ns / 100ps;
    `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
        $display("wrong value %0t: %h vs %h", $time, g, e); end end
    `define XF(c, a, d, e) begin m.frame({c, a, d}, r); `CHK(r, e) end
    `define RD(a, e) `XF(CMD_GET_REG, a, 8'h00, {ACK_OK, e})
    `define WR(a, d, k) `XF(CMD_SET_REG, a, d, {k, 8'h00})
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_link_clk, m_data, o_link_data, o_link_data_oe, hot_n;
    logic [7:0] i_status_two = 8'h00, o_target_code, o_slow_slew_rate;
    logic [9:0] r;
    logic slow, upd_p;
    int upd = 0;
    vrt_telemetry_type i_telemetry = '0;
    int num_errors = 0, comparisons = 0;
    wire logic i_link_data = o_link_data_oe ? o_link_data : m_data;
    always #5 i_clk = ~i_clk;
    vrt_regs dut (.i_clk, .i_arst_n, .i_link_clk, .i_link_data, .o_link_data, .o_link_data_oe,
        .i_telemetry, .i_status_two, .i_peak_current_program_pin(8'h80),
        .i_boot_code_strap(8'h40), .o_target_code, .o_target_slow(slow), .o_target_update(upd_p),
        .o_slow_slew_rate, .o_overtemperature_alert_out_n(hot_n));
    vrt_link_master m (.o_link_clk(i_link_clk), .o_data(m_data), .i_wire(i_link_data));
    // pulse stands one full cycle, so the falling edge sees it once
    always @(negedge i_clk) begin
        if (upd_p === 1'b1) begin
            upd++;
        end
    end
    task automatic final_report;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (40000) @(posedge i_clk);
        num_errors++;
        final_report();
    end
    task automatic t_config;
        `WR(8'h2b, 8'h00, ACK_OK)
        `RD(8'h2b, 8'h8c)
        `WR(8'h30, 8'h80, ACK_OK)
        `XF(CMD_SET_TARGET_FAST, 8'h00, 8'h81, {ACK_NOT_SUPPORTED, 8'h00})
        `CHK(o_target_code, 8'h40)
        `XF(CMD_SET_TARGET_SLOW, 8'h00, 8'h80, {ACK_OK, 8'h00})
        `CHK(slow, 1'b1)
        `RD(8'h31, 8'h80)
        for (int k = 1; k <= 4; k++) begin
            `WR(8'h2a, 8'(k), ACK_OK)
            `CHK(o_slow_slew_rate, 8'(10 >> k))
        end
        `WR(8'h2a, 8'h05, ACK_NOT_SUPPORTED)
        `RD(8'h2a, 8'h04)
        `RD(8'h24, 8'h0a)
        `RD(8'h06, 8'hd7)
        `RD(8'h2c, 8'h55)
        `RD(8'h2d, 8'hca)
        `CHK(upd, 2)
        $display("test config done");
    endtask : t_config
    task automatic t_telemetry;
        @(posedge i_clk);
        #1 i_telemetry = '{1'b1, 8'd64, 12'd1000, 12'd200, 8'd100, 16'd12000};
        i_status_two = 8'ha5;
        `RD(8'h15, 8'h7f)
        `RD(8'h16, 8'h64)
        `RD(8'h17, 8'h64)
        `RD(8'h18, 8'h31)
        `RD(8'h1a, 8'h56)
        `RD(8'h11, 8'ha5)
        `RD(8'h1c, 8'ha5)
        `CHK(hot_n, 1'b1)
        `WR(8'h22, 8'h64, ACK_OK)
        `CHK(hot_n, 1'b0)
        $display("test telemetry done");
    endtask : t_telemetry
    task automatic t_reset;
        @(posedge i_clk);
        #1 i_arst_n = 1'b0;
        i_telemetry.sense_neg_mv = 12'h000;
        i_telemetry.temp_c = 8'h00;
        repeat (2) @(posedge i_clk);
        #1 i_arst_n = 1'b1;
        `RD(8'h30, 8'hfb)
        `RD(8'h2a, 8'h01)
        `RD(8'h25, 8'h05)
        `RD(8'h22, 8'h6a)
        `RD(8'h31, 8'h40)
        `RD(8'h1c, 8'h00)
        `WR(8'h21, 8'h11, ACK_OK)
        `RD(8'h21, 8'h80)
        `RD(8'h16, 8'h7d)
        `RD(8'h17, 8'h00)
        `WR(8'h22, 8'h00, ACK_OK)
        `CHK(hot_n, 1'b1)
        `CHK(slow, 1'b0)
        `CHK(upd, 3)
        $display("test reset done");
    endtask : t_reset
    initial begin
        #16 i_arst_n = 1'b1;
        t_config();
        t_telemetry();
        t_reset();
        final_report();
    end
endmodule : vrt_regs_tb
